// [rtl/fbd_params.svh]
`ifndef FBD_PARAMS_SVH
`define FBD_PARAMS_SVH
`define FBD_WORD_W 14
`define FBD_FILE_W 7
`define FBD_BIT_W 3
`define FBD_LIT8_W 8
`define FBD_LIT11_W 11
`define FBD_DEST_POS 7
`define FBD_BITPOS_LSB 7
`define FBD_OSC_PER_CYCLE 4
`define FBD_PHASE_W 2
`define FBD_FILE_MAX 7'h7f
`define FBD_NOP_WORD 14'h0000
`define FBD_DBG_RSV_LO 11'h700
`endif

// [rtl/fbd_pkg.sv]
`include "fbd_params.svh"
package fbd_pkg;
    typedef enum logic [1:0] {
        FBD_CLASS_BYTE,
        FBD_CLASS_BIT,
        FBD_CLASS_LIT,
        FBD_CLASS_JUMP
    } fbd_class_t;
    typedef enum logic [3:0] {
        FBD_OP_NONE,
        FBD_OP_BYTE_ALU,
        FBD_OP_MOVE_TO_FILE,
        FBD_OP_CLEAR,
        FBD_OP_BIT_CLEAR,
        FBD_OP_BIT_SET,
        FBD_OP_BIT_TEST_CLR,
        FBD_OP_BIT_TEST_SET,
        FBD_OP_SKIP_COUNT,
        FBD_OP_LITERAL,
        FBD_OP_RETURN,
        FBD_OP_CALL,
        FBD_OP_JUMP,
        FBD_OP_CONTROL,
        FBD_OP_LEGACY
    } fbd_kind_t;
endpackage

// [rtl/fbd_phase_gen.sv]
`timescale 1ns/1ps
`include "fbd_params.svh"
module fbd_phase_gen (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    output logic [`FBD_PHASE_W-1:0] phase_out,
    output logic cycle_end_out
);
    import fbd_pkg::*;
    localparam logic [`FBD_PHASE_W-1:0] LAST = `FBD_PHASE_W'(`FBD_OSC_PER_CYCLE - 1);
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            phase_out <= '0;
        end else if (clk_en_in) begin
            phase_out <= (phase_out == LAST) ? '0 : phase_out + 1'b1;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cycle_end_out <= 1'b0;
        end else if (clk_en_in) begin
            cycle_end_out <= (phase_out == LAST - 1'b1);
        end
    end
endmodule

// [rtl/fbd_field_split.sv]
`timescale 1ns/1ps
`include "fbd_params.svh"
module fbd_field_split (
    input wire logic [`FBD_WORD_W-1:0] word_in,
    output logic dest_out,
    output logic [`FBD_FILE_W-1:0] file_out,
    output logic [`FBD_BIT_W-1:0] bitpos_out,
    output logic [`FBD_LIT8_W-1:0] lit8_out,
    output logic [`FBD_LIT11_W-1:0] lit11_out
);
    import fbd_pkg::*;
    always_comb begin
        dest_out = word_in[`FBD_DEST_POS];
        file_out = word_in[`FBD_FILE_W-1:0];
        bitpos_out = word_in[`FBD_BITPOS_LSB +: `FBD_BIT_W];
        lit8_out = word_in[`FBD_LIT8_W-1:0];
        lit11_out = word_in[`FBD_LIT11_W-1:0];
    end
endmodule

// [rtl/fbd_decoder.sv]
// Contract
// - Each instruction is a 14-bit word: opcode part plus operand parts.
// - Byte format: opcode 13:8, destination bit 7, file address 6:0.
// - Destination 0 writes accumulator, destination 1 writes the file register.
// - File address selects a register from 0x00 to 0x7f.
// - Bit format: opcode 13:10, bit position 9:7, file address 6:0.
// - Bit position picks one bit of the addressed 8-bit register.
// - Literal format: 8-bit immediate in bits 7:0, opcode above.
// - Call and jump: opcode 13:11, 11-bit target in bits 10:0.
// - Don't-care bits are ignored; either value decodes the same.
// - One instruction cycle is four oscillator periods.
// - Skips taken and counter changes take two cycles, second a no-op.
// - Every file-register instruction reads before it writes back.
// - Debug enable pin low enables debugger and claims clock and line pins.
`timescale 1ns/1ps
`include "fbd_params.svh"
module fbd_decoder (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [`FBD_WORD_W-1:0] instr_in,
    input wire logic skip_true_in,
    input wire logic debug_enable_pin_n_in,
    output logic [`FBD_PHASE_W-1:0] phase_out,
    output logic latch_out,
    output fbd_pkg::fbd_class_t class_out,
    output fbd_pkg::fbd_kind_t kind_out,
    output logic [5:0] opcode_out,
    output logic dest_file_out,
    output logic write_acc_out,
    output logic write_file_out,
    output logic read_file_out,
    output logic [`FBD_FILE_W-1:0] file_addr_out,
    output logic [`FBD_BIT_W-1:0] bit_pos_out,
    output logic [7:0] bit_mask_out,
    output logic [`FBD_LIT8_W-1:0] lit8_out,
    output logic [`FBD_LIT11_W-1:0] lit11_out,
    output logic flush_out,
    output logic debug_active_out,
    output logic debug_pins_claimed_out
);
    import fbd_pkg::*;

    typedef enum logic {
        FBD_ST_RUN,
        FBD_ST_FLUSH
    } fbd_state_t;

    logic [`FBD_PHASE_W-1:0] phase;
    logic cycle_end;
    logic f_dest;
    logic [`FBD_FILE_W-1:0] f_file;
    logic [`FBD_BIT_W-1:0] f_bit;
    logic [`FBD_LIT8_W-1:0] f_lit8;
    logic [`FBD_LIT11_W-1:0] f_lit11;
    fbd_class_t next_class;
    fbd_kind_t next_kind;
    logic next_dest_file;
    logic next_uses_file;
    logic next_two_cycle;
    logic next_cond;
    fbd_state_t state;
    fbd_state_t next_state;
    logic [`FBD_WORD_W-1:0] word;
    logic cur_cond;
    logic next_two_cycle_q;
    logic dbg_s1;
    logic dbg_s2;

    fbd_phase_gen u_phase (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .phase_out(phase),
        .cycle_end_out(cycle_end)
    );

    // Second cycle of a flushed instruction sees a no-op word
    assign word = (next_state == FBD_ST_FLUSH) ? `FBD_NOP_WORD : instr_in;

    fbd_field_split u_split (
        .word_in(word),
        .dest_out(f_dest),
        .file_out(f_file),
        .bitpos_out(f_bit),
        .lit8_out(f_lit8),
        .lit11_out(f_lit11)
    );

    function automatic logic [7:0] fbd_onehot(input logic [`FBD_BIT_W-1:0] pos);
        fbd_onehot = 8'h01 << pos;
    endfunction

    // Opcode bits of each format are compared except literal bits 9:8, plus bits 7:0 in the 00 0000 group, where all four NOP x values match
    always_comb begin
        next_class = FBD_CLASS_BYTE;
        next_kind = FBD_OP_NONE;
        next_dest_file = 1'b0;
        next_uses_file = 1'b0;
        next_two_cycle = 1'b0;
        next_cond = 1'b0;
        unique case (word[13:12])
            2'b00: begin
                next_class = FBD_CLASS_BYTE;
                if (word[11:8] == 4'h0 && !word[7]) begin
                    if (word[6:0] == 7'h00 || word[6:0] == 7'h20 || word[6:0] == 7'h40
                        || word[6:0] == 7'h60) begin
                        next_kind = FBD_OP_NONE;
                    end else if (word[6:0] == 7'h08 || word[6:0] == 7'h09) begin
                        next_kind = FBD_OP_RETURN;
                        next_two_cycle = 1'b1;
                    end else if (word[6:0] == 7'h62 || word[6:4] == 3'h0) begin
                        next_kind = FBD_OP_LEGACY;
                    end else begin
                        next_kind = FBD_OP_CONTROL;
                    end
                end else if (word[11:8] == 4'h0) begin
                    next_kind = FBD_OP_MOVE_TO_FILE;
                    next_dest_file = 1'b1;
                    next_uses_file = 1'b1;
                end else if (word[11:8] == 4'h1) begin
                    next_kind = FBD_OP_CLEAR;
                    next_dest_file = word[7];
                    next_uses_file = word[7];
                end else begin
                    next_kind = (word[11:8] == 4'hb || word[11:8] == 4'hf)
                        ? FBD_OP_SKIP_COUNT : FBD_OP_BYTE_ALU;
                    next_cond = (word[11:8] == 4'hb || word[11:8] == 4'hf);
                    next_dest_file = f_dest;
                    next_uses_file = 1'b1;
                end
            end
            2'b01: begin
                next_class = FBD_CLASS_BIT;
                next_uses_file = 1'b1;
                unique case (word[11:10])
                    2'b00: next_kind = FBD_OP_BIT_CLEAR;
                    2'b01: next_kind = FBD_OP_BIT_SET;
                    2'b10: next_kind = FBD_OP_BIT_TEST_CLR;
                    2'b11: next_kind = FBD_OP_BIT_TEST_SET;
                endcase
                next_dest_file = !word[11];
                next_cond = word[11];
            end
            2'b10: begin
                next_class = FBD_CLASS_JUMP;
                next_kind = word[11] ? FBD_OP_JUMP : FBD_OP_CALL;
                next_two_cycle = 1'b1;
            end
            2'b11: begin
                next_class = FBD_CLASS_LIT;
                next_kind = (word[11:10] == 2'b01) ? FBD_OP_RETURN : FBD_OP_LITERAL;
                next_two_cycle = (word[11:10] == 2'b01);
            end
        endcase
    end

    // A skip is only known once the datapath has tested the operand, late in the cycle
    always_comb begin
        next_state = state;
        if (cycle_end) begin
            next_state = FBD_ST_RUN;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= FBD_ST_RUN;
        end else if (clk_en_in && cycle_end) begin
            if (state == FBD_ST_FLUSH) begin
                state <= FBD_ST_RUN;
            end else if (next_two_cycle_q || (cur_cond && skip_true_in)) begin
                state <= FBD_ST_FLUSH;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            next_two_cycle_q <= 1'b0;
            cur_cond <= 1'b0;
        end else if (clk_en_in && phase == '0) begin
            next_two_cycle_q <= next_two_cycle && state == FBD_ST_RUN;
            cur_cond <= next_cond && state == FBD_ST_RUN;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            latch_out <= 1'b0;
            class_out <= FBD_CLASS_BYTE;
            kind_out <= FBD_OP_NONE;
            opcode_out <= '0;
            dest_file_out <= 1'b0;
            write_acc_out <= 1'b0;
            write_file_out <= 1'b0;
            read_file_out <= 1'b0;
            file_addr_out <= '0;
            bit_pos_out <= '0;
            bit_mask_out <= '0;
            lit8_out <= '0;
            lit11_out <= '0;
            flush_out <= 1'b0;
        end else if (clk_en_in) begin
            latch_out <= (phase == '0);
            if (phase == '0) begin
                // Word, class and every field latch on one edge
                class_out <= next_class;
                kind_out <= next_kind;
                opcode_out <= word[13:8];
                dest_file_out <= next_dest_file;
                // Clearing the accumulator names no file but still lands there
                write_acc_out <= next_class == FBD_CLASS_BYTE && word[11:8] != 4'h0
                    && !next_dest_file;
                write_file_out <= next_uses_file && next_dest_file;
                read_file_out <= next_uses_file;
                file_addr_out <= f_file & `FBD_FILE_MAX;
                bit_pos_out <= f_bit;
                bit_mask_out <= fbd_onehot(f_bit);
                lit8_out <= f_lit8;
                lit11_out <= f_lit11;
                flush_out <= (state == FBD_ST_FLUSH);
            end
        end
    end

    // Strap pin is asynchronous to the core clock
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dbg_s1 <= 1'b1;
            dbg_s2 <= 1'b1;
        end else if (clk_en_in) begin
            dbg_s1 <= debug_enable_pin_n_in;
            dbg_s2 <= dbg_s1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            debug_active_out <= 1'b0;
            debug_pins_claimed_out <= 1'b0;
        end else if (clk_en_in) begin
            debug_active_out <= !dbg_s2;
            debug_pins_claimed_out <= !dbg_s2;
        end
    end

    assign phase_out = phase;
endmodule

// [verification/fbd_decoder_assertions.sv]
`timescale 1ns/1ps
`include "fbd_params.svh"
module fbd_decoder_checker (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [`FBD_WORD_W-1:0] instr_in,
    input wire logic debug_enable_pin_n_in,
    input wire logic [`FBD_PHASE_W-1:0] phase_out,
    input wire logic latch_out,
    input wire fbd_pkg::fbd_class_t class_out,
    input wire fbd_pkg::fbd_kind_t kind_out,
    input wire logic [5:0] opcode_out,
    input wire logic dest_file_out,
    input wire logic write_acc_out,
    input wire logic write_file_out,
    input wire logic read_file_out,
    input wire logic [`FBD_FILE_W-1:0] file_addr_out,
    input wire logic [`FBD_BIT_W-1:0] bit_pos_out,
    input wire logic [7:0] bit_mask_out,
    input wire logic [`FBD_LIT8_W-1:0] lit8_out,
    input wire logic [`FBD_LIT11_W-1:0] lit11_out,
    input wire logic flush_out,
    input wire logic debug_active_out,
    input wire logic debug_pins_claimed_out
);
    import fbd_pkg::*;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    property p_latch_follows;
        !rst_in && clk_en_in && phase_out == 2'd0 |=> latch_out;
    endproperty
    a_latch_follows: assert property (p_latch_follows) else $error("no latch after fetch");
    property p_cycle_len;
        latch_out && clk_en_in ##1 clk_en_in [*3] |-> !latch_out ##1 latch_out;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle is not four clocks");
    // Rising edge only: a frozen latch cycle would point past the sampled word
    property p_byte_fields;
        $rose(latch_out) && !flush_out && class_out == FBD_CLASS_BYTE
            |-> {opcode_out, dest_file_out, file_addr_out} == $past(instr_in);
    endproperty
    a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong");
    property p_bit_fields;
        $rose(latch_out) && !flush_out && class_out == FBD_CLASS_BIT
            |-> {bit_pos_out, file_addr_out} == $past(instr_in[9:0])
            && bit_mask_out == 8'h01 << bit_pos_out;
    endproperty
    a_bit_fields: assert property (p_bit_fields) else $error("bit fields wrong");
    property p_imm_fields;
        $rose(latch_out) && !flush_out
            |-> (class_out != FBD_CLASS_LIT || lit8_out == $past(instr_in[7:0]))
            && (class_out != FBD_CLASS_JUMP || lit11_out == $past(instr_in[10:0]));
    endproperty
    a_imm_fields: assert property (p_imm_fields) else $error("literal wrong");
    property p_dest_write;
        latch_out && !flush_out && opcode_out[5:4] == 2'b00
            && {opcode_out[3:0], dest_file_out} != 5'h00
            |-> write_acc_out != dest_file_out && write_file_out == dest_file_out;
    endproperty
    a_dest_write: assert property (p_dest_write) else $error("destination wrong");
    property p_rmw_read;
        latch_out && !flush_out && (class_out == FBD_CLASS_BIT || opcode_out[5:4] == 2'b00
            && !({opcode_out[3:0], dest_file_out} inside {5'h00, 5'h02})) |-> read_file_out;
    endproperty
    a_rmw_read: assert property (p_rmw_read) else $error("file not read");
    property p_two_cycle;
        latch_out && clk_en_in && !flush_out && class_out == FBD_CLASS_JUMP ##1 clk_en_in [*3]
            |=> flush_out && kind_out == FBD_OP_NONE && !write_acc_out && !write_file_out;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("no no-op after jump");
    property p_debug;
        $changed(debug_enable_pin_n_in) && clk_en_in
            ##1 (clk_en_in && $stable(debug_enable_pin_n_in)) [*4]
            |-> debug_active_out != debug_enable_pin_n_in
            && debug_pins_claimed_out != debug_enable_pin_n_in;
    endproperty
    a_debug: assert property (p_debug) else $error("debug strap not followed");
endmodule
bind fbd_decoder fbd_decoder_checker u_fbd_chk (.*);

// [verification/fbd_prog_mem_model.sv]
`timescale 1ns/1ps
module fbd_prog_mem_model (
    input wire logic core_clk_in,
    input wire logic [1:0] phase_in,
    input wire logic [13:0] word_in,
    input wire logic skip_in,
    output logic [13:0] instr_out,
    output logic skip_true_out
);
    logic skip_held;
    initial begin
        instr_out = 14'h0000;
        skip_true_out = 1'b0;
        skip_held = 1'b0;
    end
    // Off its own phase each line shows the inverse, so a mistimed sample is caught
    // The skip answer belongs to the word fetched this cycle and is taken at the last phase
    always @(negedge core_clk_in) begin
        instr_out <= phase_in == 2'd0 ? word_in : ~word_in;
        if (phase_in == 2'd0) begin
            skip_held <= skip_in;
        end
        skip_true_out <= phase_in == 2'd3 ? skip_held : ~skip_held;
    end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import fbd_pkg::*;
    typedef struct packed {logic [13:0] w; logic fl; logic sk;} fbd_note_t;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic debug_enable_pin_n_in = 1'b1;
    logic [13:0] instr_in;
    logic skip_true_in;
    logic [13:0] word_q = 14'h0000;
    logic skip_q = 1'b0;
    logic [1:0] phase_out;
    fbd_class_t class_out;
    fbd_kind_t kind_out;
    logic [5:0] opcode_out;
    logic latch_out, dest_file_out, write_acc_out, write_file_out, read_file_out, flush_out;
    logic debug_active_out, debug_pins_claimed_out;
    logic [6:0] file_addr_out;
    logic [2:0] bit_pos_out;
    logic [7:0] bit_mask_out, lit8_out;
    logic [10:0] lit11_out;
    logic [31:0] rng = 32'h6276;
    logic [31:0] r;
    logic [13:0] w;
    logic fl_next = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    fbd_note_t notes[$];
    fbd_note_t prog[$];
    fbd_note_t nx;
    fbd_note_t n;
    logic [13:0] dir [11] = '{14'h3055, 14'h3355, 14'h0008, 14'h3000, 14'h0100, 14'h00ff,
        14'h1fff, 14'h1fff, 14'h2fff, 14'h2000, 14'h0000};
    always #12.5 core_clk_in = ~core_clk_in;
    fbd_prog_mem_model pm (.core_clk_in(core_clk_in), .phase_in(phase_out), .word_in(word_q),
        .skip_in(skip_q), .instr_out(instr_in), .skip_true_out(skip_true_in));
    fbd_decoder dut (.*);
    function automatic logic [31:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic idle();
        while (prog.size() != 0) @(negedge core_clk_in);
        repeat (8) @(negedge core_clk_in);
    endtask
    // Feeder: one word per cycle, a no-op when nothing is queued
    always @(negedge core_clk_in) begin
        if (phase_out === 2'd3 && clk_en_in === 1'b1 && rst_in === 1'b0) begin
            nx = prog.size() != 0 ? prog.pop_front() : '0;
            nx.fl = fl_next;
            nx.sk = nx.sk && !fl_next;
            fl_next = !nx.fl && (nx.w[13:12] == 2'b10 || nx.w[13:10] == 4'b1101
                || nx.w == 14'h0008 || nx.sk);
            word_q = nx.w;
            skip_q = nx.sk;
            notes.push_back(nx);
        end
    end
    always @(negedge core_clk_in) begin
        if (latch_out === 1'b1) begin
            n = notes.size() != 0 ? notes.pop_front() : '1;
            w = n.w;
            check("flush", n.fl, flush_out);
            if (n.fl) begin
                check("nop", {FBD_OP_NONE, 2'b00}, {kind_out, write_acc_out, write_file_out});
            end else if (w[13:12] == 2'b00 && w[11:7] != 5'h00) begin
                check("byte", {FBD_CLASS_BYTE, w[7:0]}, {class_out, dest_file_out, file_addr_out});
                check("dest", {~w[7], w[7]}, {write_acc_out, write_file_out});
                check("read", w[11:7] != 5'h02, read_file_out);
            end else if (w[13:12] == 2'b01) begin
                check("bit", {FBD_CLASS_BIT, w[9:0]}, {class_out, bit_pos_out, file_addr_out});
                check("mask", 8'h01 << w[9:7], bit_mask_out);
                check("rmw", {1'b1, ~w[11]}, {read_file_out, write_file_out});
            end else if (w[13:12] == 2'b11) begin
                check("lit", {FBD_CLASS_LIT, w[7:0]}, {class_out, lit8_out});
                if (w[11:10] == 2'b00) check("kind", FBD_OP_LITERAL, kind_out);
            end else if (w[13:12] == 2'b10) begin
                check("jump", {FBD_CLASS_JUMP, w[10:0]}, {class_out, lit11_out});
            end
            if (!n.fl) check("opcode", w[13:8], opcode_out);
        end
    end
    initial begin
        notes.push_back('0); // Address zero holds a no-op, as a debugger session needs
        repeat (5) @(negedge core_clk_in);
        check("reset", 0, {phase_out, latch_out, flush_out, write_acc_out, debug_active_out});
        rst_in = 1'b0;
        $display("test reset done");
        foreach (dir[i]) prog.push_back('{dir[i], 1'b0, dir[i][13:11] == 3'b011});
        idle();
        $display("test directed done");
        repeat (48) begin
            r = nxt();
            w = {r[31:30], r[11:0]};
            if (w[13:8] == 6'h00) w[11:8] = 4'h9; // Legacy loads stay out of traffic
            prog.push_back('{w, 1'b0, w[13:11] == 3'b011 && r[20]});
        end
        idle();
        $display("test random done");
        while (phase_out !== 2'd2) @(negedge core_clk_in);
        clk_en_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        check("freeze", 2'd2, phase_out);
        clk_en_in = 1'b1;
        $display("test freeze done");
        for (int v = 0; v < 2; v++) begin
            debug_enable_pin_n_in = v[0];
            repeat (5) @(negedge core_clk_in);
            check("debug", {2{~v[0]}}, {debug_active_out, debug_pins_claimed_out});
        end
        check("pending", 1, notes.size() < 3);
        $display("test debug done");
        print_verdict();
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
